//--- core/stso_pkg.sv
// Constants and types of the serial time string output block
package stso_pkg;
  localparam int STSO_CLK_HZ = 250_000_000;
  localparam int STSO_CLK_NS = 4;
  localparam int STSO_ONTIME_NS = 100_000;
  localparam int STSO_ONTIME_CYC = STSO_ONTIME_NS / STSO_CLK_NS;
  localparam int STSO_PPS_LAT = 4;
  localparam int STSO_BAUD_57600 = 57600;
  localparam int STSO_BAUD_19200 = 19200;
  localparam int STSO_BAUD_9600 = 9600;
  localparam int STSO_BAUD_4800 = 4800;
  localparam logic [31:0] STSO_ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] STSO_ADDR_STAT = 32'h0000_0004;
  localparam int STSO_CTRL_EN_BIT = 0;
  localparam int STSO_CTRL_FMT_LSB = 1;
  localparam int STSO_CTRL_BAUD_LSB = 4;
  localparam int STSO_CTRL_PAR_LSB = 6;
  localparam int STSO_CTRL_LAY_LSB = 8;
  localparam int STSO_CTRL_MASK_LSB = 10;
  localparam logic [15:0] STSO_CTRL_RST = 16'h8021;
  localparam int STSO_STAT_MISS_BIT = 3;
  localparam logic [5:0] STSO_OT_CLUSTER = 6'h0e;
  localparam logic [7:0] STSO_ASC_SOH = 8'h01;
  localparam logic [7:0] STSO_ASC_COLON = 8'h3a;
  localparam logic [7:0] STSO_ASC_SPACE = 8'h20;
  localparam logic [7:0] STSO_ASC_QMARK = 8'h3f;
  localparam logic [7:0] STSO_ASC_CR = 8'h0d;
  localparam logic [7:0] STSO_ASC_LF = 8'h0a;
  localparam logic [7:0] STSO_ASC_ZERO = 8'h30;
  localparam logic [7:0] STSO_ASC_DOLLAR = 8'h24;
  localparam logic [7:0] STSO_ASC_PLUS = 8'h2b;
  localparam logic [7:0] STSO_ASC_MINUS = 8'h2d;
  localparam logic [167:0] STSO_WDAY_NAMES = "MONTUEWEDTHUFRISATSUN";
  localparam logic [287:0] STSO_MON_NAMES = "JANFEBMARAPRMAYJUNJULAUGSEPOCTNOVDEC";
  localparam logic [143:0] STSO_NMEA_IDS = "GGAGLLGSARMCVTGZDA";
  localparam logic [31:0] STSO_DST_CHARS = "SIDO";
  localparam logic [23:0] STSO_MODE_CHARS = "GLU";

  typedef enum logic [2:0] {
    STSO_FMT_CLUSTER = 3'h0,
    STSO_FMT_LOCAL = 3'h1,
    STSO_FMT_MERIT = 3'h2,
    STSO_FMT_MERITX = 3'h3,
    STSO_FMT_EMERG = 3'h4,
    STSO_FMT_MARINE = 3'h5
  } stso_fmt_t;

  typedef enum logic [1:0] {
    STSO_PAR_NONE = 2'h0,
    STSO_PAR_ODD = 2'h1,
    STSO_PAR_EVEN = 2'h2
  } stso_par_t;

  typedef enum logic [1:0] {
    STSO_MODE_GPS = 2'h0,
    STSO_MODE_LOCAL = 2'h1,
    STSO_MODE_UTC = 2'h2
  } stso_mode_t;

  typedef enum logic [1:0] {
    STSO_ST_IDLE = 2'h0,
    STSO_ST_LOAD = 2'h1,
    STSO_ST_WAIT = 2'h3,
    STSO_ST_TX = 2'h2
  } stso_st_t;

  typedef struct packed {
    logic [13:0] year;
    logic [8:0] doy;
    logic [3:0] month;
    logic [4:0] mday;
    logic [2:0] wday;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
    logic [3:0] merit;
    logic locked;
    stso_mode_t mode;
    logic off_neg;
    logic [4:0] off_half;
    logic [4:0] zone;
    logic [1:0] dst;
    logic [7:0] leap_cur;
    logic [7:0] leap_fut;
  } stso_time_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } stso_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } stso_apb_rsp_t;
endpackage : stso_pkg

//--- core/stso_serial_time.sv
// Once-per-second serial time string transmitter with APB control
`timescale 1ns/1ps
module stso_serial_time
  import stso_pkg::*;
#(
  parameter int CLK_HZ = STSO_CLK_HZ,
  parameter int ONTIME_CYC = STSO_ONTIME_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire stso_apb_req_t apb_req,
  output stso_apb_rsp_t apb_rsp,
  input wire logic pps_pin,
  input wire stso_time_t time_in,
  input wire stso_time_t utc_in,
  output logic txd,
  output logic ontime_strobe
);

  if (CLK_HZ / STSO_BAUD_57600 < 16 || CLK_HZ / STSO_BAUD_4800 > 131071)
  begin : g_chk_clk
    $error("stso: clock rate outside divider range");
  end
  if (ONTIME_CYC < STSO_PPS_LAT) begin : g_chk_ontime
    $error("stso: on-time window shorter than pulse latency");
  end

  typedef struct packed {
    stso_st_t st;
    logic [2:0] pps;
    logic rel;
    logic [5:0] idx;
    logic [1:0] slot;
    stso_fmt_t fmt;
    logic [1:0] baud;
    stso_par_t par;
    logic [1:0] lay;
    logic [5:0] mask;
    stso_time_t tm;
    logic [10:0] sh;
    logic [3:0] bcnt;
    logic [16:0] div;
    logic late;
    logic line;
    logic ots;
    logic [15:0] ctrl;
    logic [15:0] sent;
    logic [31:0] rdata;
    logic slverr;
  } stso_state_t;

  stso_state_t s;
  stso_state_t s_next;

  function automatic logic [16:0] bdiv(input logic [1:0] c);
    case (c)
      2'h0: return 17'(CLK_HZ / STSO_BAUD_57600 - 1);
      2'h1: return 17'(CLK_HZ / STSO_BAUD_19200 - 1);
      2'h2: return 17'(CLK_HZ / STSO_BAUD_9600 - 1);
      default: return 17'(CLK_HZ / STSO_BAUD_4800 - 1);
    endcase
  endfunction : bdiv

  function automatic logic [7:0] dg(input logic [13:0] v, input int p);
    logic [13:0] q;
    q = v;
    for (int k = 0; k < p; k++) begin
      q = q / 14'd10;
    end
    return STSO_ASC_ZERO + 8'(q % 14'd10);
  endfunction : dg

  // Two-digit hour, minute and second, second may read 60
  function automatic logic [7:0] hms(input stso_time_t t, input int k);
    case (k)
      0: return dg(14'(t.hour), 1);
      1: return dg(14'(t.hour), 0);
      3: return dg(14'(t.minute), 1);
      4: return dg(14'(t.minute), 0);
      6: return dg(14'(t.second), 1);
      7: return dg(14'(t.second), 0);
      default: return STSO_ASC_COLON;
    endcase
  endfunction : hms

  always_comb begin
    stso_state_t n;
    logic [7:0] ch;
    logic last;
    logic [5:0] ot;
    logic start;
    logic pps_rise;
    logic setup;
    logic wr;
    logic [10:0] frame;
    logic [3:0] nb;
    logic [7:0] q;
    logic [7:0] sg;
    logic [7:0] mc;
    logic [13:0] mag;
    int i;
    int j;
    int cnt;
    int sid;
    int nsen;
    n = s;
    ch = STSO_ASC_SPACE;
    last = 1'b0;
    ot = 6'h00;
    start = 1'b0;
    frame = 11'h7ff;
    nb = 4'd10;
    i = int'(s.idx);
    j = i - 3;
    cnt = 0;
    sid = 5;
    nsen = 1;
    pps_rise = s.pps[1] & ~s.pps[2];
    setup = apb_req.psel & ~apb_req.penable;
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    q = s.tm.locked ? STSO_ASC_SPACE : STSO_ASC_QMARK;
    // Offset forced to zero outside local mode
    mag = (s.tm.mode == STSO_MODE_LOCAL) ? 14'(s.tm.off_half) : 14'h0000;
    sg = s.tm.off_neg ? STSO_ASC_MINUS : STSO_ASC_PLUS;
    // Merit digit clamped to 3..9, 9 when unsynchronized
    if (!s.tm.locked || s.tm.merit > 4'd9) begin
      mc = STSO_ASC_ZERO + 8'h09;
    end else if (s.tm.merit < 4'd3) begin
      mc = STSO_ASC_ZERO + 8'h03;
    end else begin
      mc = STSO_ASC_ZERO + 8'(s.tm.merit);
    end
    // Pick selected sentences, at most three
    for (int b = 0; b < 6; b++) begin
      if (s.mask[b]) begin
        if (cnt == int'(s.slot)) begin
          sid = b;
        end
        cnt = cnt + 1;
      end
    end
    if (cnt > 3) begin
      nsen = 3;
    end else if (cnt > 0) begin
      nsen = cnt;
    end

    case (s.fmt)
      STSO_FMT_CLUSTER, STSO_FMT_LOCAL: begin
        ot = STSO_OT_CLUSTER;
        if (i == 0) ch = STSO_ASC_SOH;
        else if (i < 4) ch = dg(14'(s.tm.doy), 3 - i);
        else if (i == 4) ch = STSO_ASC_COLON;
        else if (i < 13) ch = hms(s.tm, i - 5);
        else if (i == 13) ch = q;
        else if (i == 14) ch = STSO_ASC_CR;
        else begin
          ch = STSO_ASC_LF;
          last = 1'b1;
        end
      end
      STSO_FMT_MERIT, STSO_FMT_MERITX: begin
        // Merit layout, merit digit first and on time
        if (i == 0) ch = mc;
        else if (i > 1 && i < 6) ch = dg(s.tm.year, 5 - i);
        else if (i > 6 && i < 10) ch = dg(14'(s.tm.doy), 9 - i);
        else if (i > 10 && i < 19) ch = hms(s.tm, i - 11);
        else if (i == 20) ch = sg;
        else if (i == 21 || i == 22) ch = dg(mag, 22 - i);
        else if (i == 24) ch = STSO_MODE_CHARS[8 * (2 - int'(s.tm.mode)) +: 8];
        else if (s.fmt == STSO_FMT_MERIT && i == 25) ch = STSO_ASC_CR;
        else if (s.fmt == STSO_FMT_MERIT && i > 25) begin
          ch = STSO_ASC_LF;
          last = 1'b1;
        end
        else if (i == 26 || i == 27) ch = dg(14'(s.tm.leap_cur), 27 - i);
        else if (i == 29 || i == 30) ch = dg(14'(s.tm.leap_fut), 30 - i);
        else if (i == 31) ch = STSO_ASC_CR;
        else if (i > 31) begin
          ch = STSO_ASC_LF;
          last = 1'b1;
        end
      end
      STSO_FMT_EMERG: begin
        // Leading CR LF, first CR on time
        if (i == 0) ch = STSO_ASC_CR;
        else if (i == 1) ch = STSO_ASC_LF;
        else if (i == 2) ch = q;
        else if (s.lay == 2'h1) begin
          if (j > 0 && j < 4)
            ch = STSO_WDAY_NAMES[8 * (20 - 3 * int'(s.tm.wday) - j + 1) +: 8];
          else if (j == 5 || j == 6) ch = dg(14'(s.tm.mday), 6 - j);
          else if (j > 6 && j < 10)
            ch = STSO_MON_NAMES[8 * (38 - 3 * int'(s.tm.month) - j + 7) +: 8];
          else if (j == 10 || j == 11) ch = dg(s.tm.year, 11 - j);
          else if (j > 12 && j < 21) ch = hms(s.tm, j - 13);
          else if (j == 21) ch = STSO_ASC_CR;
          else if (j > 21) begin
            ch = STSO_ASC_LF;
            last = 1'b1;
          end
        end else if (s.lay == 2'h2) begin
          // Year, day, time, flag, signed offset
          if (j > 1 && j < 6) ch = dg(s.tm.year, 5 - j);
          else if (j > 6 && j < 10) ch = dg(14'(s.tm.doy), 9 - j);
          else if (j > 10 && j < 19) ch = hms(s.tm, j - 11);
          else if (j == 20) ch = STSO_DST_CHARS[8 * (3 - int'(s.tm.dst)) +: 8];
          else if (j == 21) ch = sg;
          else if (j == 22 || j == 23) ch = dg(mag >> 1, 23 - j);
          else if (j == 24) ch = STSO_ASC_CR;
          else if (j > 24) begin
            ch = STSO_ASC_LF;
            last = 1'b1;
          end
        end else begin
          if (j > 1 && j < 5) ch = dg(14'(s.tm.doy), 4 - j);
          else if (j > 5 && j < 14) ch = hms(s.tm, j - 6);
          else if (j == 15) ch = STSO_DST_CHARS[8 * (3 - int'(s.tm.dst)) +: 8];
          else if (j == 16) ch = "T";
          else if (j == 17) ch = "Z";
          else if (j == 18) ch = "=";
          else if (j == 19 || j == 20) ch = dg(14'(s.tm.zone), 20 - j);
          else if (j == 21) ch = STSO_ASC_CR;
          else if (j > 21) begin
            ch = STSO_ASC_LF;
            last = 1'b1;
          end
        end
      end
      default: begin
        // Dollar sign of first sentence is on time
        if (i == 0) ch = STSO_ASC_DOLLAR;
        else if (i == 1) ch = "G";
        else if (i == 2) ch = "P";
        else if (i < 6) ch = STSO_NMEA_IDS[8 * (17 - 3 * sid - i + 3) +: 8];
        else if (i == 6) ch = STSO_ASC_CR;
        else begin
          ch = STSO_ASC_LF;
          last = (int'(s.slot) >= nsen - 1);
        end
      end
    endcase

    // Start, data LSB first, optional parity, stop
    case (s.par)
      STSO_PAR_ODD: begin
        frame = {1'b1, ~^ch, ch, 1'b0};
        nb = 4'd11;
      end
      STSO_PAR_EVEN: begin
        frame = {1'b1, ^ch, ch, 1'b0};
        nb = 4'd11;
      end
      default: begin
        frame = {2'b11, ch, 1'b0};
        nb = 4'd10;
      end
    endcase

    n.pps = {s.pps[1], s.pps[0], pps_pin};
    n.ots = 1'b0;
    case (s.st)
      STSO_ST_IDLE: begin
        // Enabled from reset, so strings start alone
        if (s.ctrl[STSO_CTRL_EN_BIT]) begin
          n.st = STSO_ST_LOAD;
        end
      end
      STSO_ST_LOAD: begin
        // Format select, changed only between strings
        n.fmt = (s.ctrl[STSO_CTRL_FMT_LSB +: 3] > 3'h5) ? STSO_FMT_CLUSTER
              : stso_fmt_t'(s.ctrl[STSO_CTRL_FMT_LSB +: 3]);
        n.baud = s.ctrl[STSO_CTRL_BAUD_LSB +: 2];
        n.par = stso_par_t'(s.ctrl[STSO_CTRL_PAR_LSB +: 2]);
        n.lay = s.ctrl[STSO_CTRL_LAY_LSB +: 2];
        n.mask = s.ctrl[STSO_CTRL_MASK_LSB +: 6];
        // Only the plain cluster format forces UTC
        n.tm = (n.fmt == STSO_FMT_CLUSTER) ? utc_in : time_in;
        n.idx = 6'h00;
        n.slot = 2'h0;
        n.rel = 1'b0;
        n.st = STSO_ST_WAIT;
      end
      STSO_ST_WAIT: begin
        // Hold at the on-time character until the pulse
        if (s.idx == ot && !s.rel) begin
          if (pps_rise) begin
            n.rel = 1'b1;
            n.ots = 1'b1;
            start = 1'b1;
          end
        end else begin
          start = 1'b1;
        end
      end
      STSO_ST_TX: begin
        n.div = s.div + 17'h00001;
        if (s.div == bdiv(s.baud)) begin
          n.div = 17'h00000;
          n.sh = {1'b1, s.sh[10:1]};
          n.bcnt = s.bcnt + 4'h1;
          if (s.bcnt == nb - 4'h1) begin
            if (last) begin
              n.sent = s.sent + 16'h0001;
              n.st = s.ctrl[STSO_CTRL_EN_BIT] ? STSO_ST_LOAD : STSO_ST_IDLE;
            end else if (s.fmt == STSO_FMT_MARINE && s.idx == 6'h07) begin
              n.slot = s.slot + 2'h1;
              n.idx = 6'h00;
              n.st = STSO_ST_WAIT;
            end else begin
              n.idx = s.idx + 6'h01;
              n.st = STSO_ST_WAIT;
            end
          end
        end
      end
      default: n.st = STSO_ST_IDLE;
    endcase
    if (start) begin
      // Divider restarts with the start bit so the edge falls with the strobe
      n.sh = frame;
      n.bcnt = 4'h0;
      n.div = 17'h00000;
      n.st = STSO_ST_TX;
    end
    n.line = (n.st == STSO_ST_TX) ? n.sh[0] : 1'b1;

    if (wr && apb_req.paddr == STSO_ADDR_CTRL) begin
      n.ctrl = apb_req.pwdata[15:0];
    end
    if (wr && apb_req.paddr == STSO_ADDR_STAT &&
        apb_req.pwdata[STSO_STAT_MISS_BIT]) begin
      n.late = 1'b0;
    end
    // A second whose on-time character could not be sent; set beats clear
    if (pps_rise && s.ctrl[STSO_CTRL_EN_BIT] &&
        !(s.st == STSO_ST_WAIT && s.idx == ot && !s.rel)) begin
      n.late = 1'b1;
    end
    if (setup) begin
      n.slverr = 1'b0;
      if (apb_req.paddr == STSO_ADDR_CTRL) begin
        n.rdata = {16'h0000, s.ctrl};
      end else if (apb_req.paddr == STSO_ADDR_STAT) begin
        n.rdata = {s.sent, 12'h000, s.late, time_in.locked,
                   s.st == STSO_ST_WAIT && s.idx == ot && !s.rel,
                   s.st != STSO_ST_IDLE};
      end else begin
        n.rdata = 32'h0000_0000;
        n.slverr = 1'b1;
      end
    end
    s_next = n;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.line <= 1'b1;
      s.ctrl <= STSO_CTRL_RST;
    end else begin
      s <= s_next;
    end
  end

  assign apb_rsp.prdata = s.rdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = s.slverr;
  assign txd = s.line;
  assign ontime_strobe = s.ots;

endmodule : stso_serial_time

//--- dv/stso_serial_time_props.sv
// Port-level checks for the serial time string block
`timescale 1ns/1ps
module stso_serial_time_props
  import stso_pkg::*;
#(
  parameter int CLK_HZ = STSO_CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire stso_apb_req_t apb_req,
  input wire stso_apb_rsp_t apb_rsp,
  input wire logic pps_pin,
  input wire stso_time_t time_in,
  input wire stso_time_t utc_in,
  input wire logic txd,
  input wire logic ontime_strobe
);
  // Longest legal low run: start, eight zero bits, zero parity at 4800
  localparam int MAX_LOW = 10 * (CLK_HZ / 4800);
  logic acc;
  logic mapped;
  int low_cnt_reg;
  int low_cnt_next;
  assign acc = apb_req.psel && apb_req.penable;
  assign mapped = (apb_req.paddr == STSO_ADDR_CTRL) ||
                  (apb_req.paddr == STSO_ADDR_STAT);
  always_comb begin
    low_cnt_next = txd ? 0 : low_cnt_reg + 1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_reg <= 0;
    end else begin
      low_cnt_reg <= low_cnt_next;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_READY: assert property (acc |-> apb_rsp.pready)
    else $error("pready low in access phase");
  AST_UNMAPPED_ERR: assert property (acc && !mapped |-> apb_rsp.pslverr)
    else $error("no error on unmapped access");
  AST_MAPPED_OK: assert property (acc && mapped |-> !apb_rsp.pslverr)
    else $error("error on mapped access");
  AST_CTRL_UPPER: assert property (acc && !apb_req.pwrite &&
    apb_req.paddr == STSO_ADDR_CTRL |-> apb_rsp.prdata[31:16] == 16'h0)
    else $error("control upper half not zero");
  AST_STROBE_FALL: assert property (ontime_strobe |-> $fell(txd))
    else $error("strobe without start bit edge");
  AST_ONTIME_LAT: assert property (ontime_strobe |->
    $past(pps_pin, 3) && !$past(pps_pin, 4))
    else $error("on-time start not four edges after pps");
  AST_START_HOLD: assert property (ontime_strobe |=>
    (!txd && !ontime_strobe) [*7])
    else $error("start bit too short or strobe repeated");
  AST_LOW_RUN: assert property (low_cnt_reg <= MAX_LOW)
    else $error("serial line low beyond one frame");
endmodule : stso_serial_time_props

//--- dv/stso_rx_model.sv
// Receiving computer model: samples the serial line and checks framing
`timescale 1ns/1ps
module stso_rx_model
  import stso_pkg::*;
(
  input wire logic pclk,
  input wire logic txd,
  input wire logic [7:0] bit_cyc,
  input wire stso_par_t par,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rx_err
);
  logic [7:0] d;
  initial begin
    rx_byte = '0;
    rx_valid = 1'b0;
    rx_err = 1'b0;
    forever begin
      @(posedge pclk);
      if (txd === 1'b0) begin
        // mid start bit at set rate
        repeat (bit_cyc / 2) @(posedge pclk);
        if (txd !== 1'b0) rx_err = 1'b1;
        for (int i = 0; i < 8; i++) begin
          repeat (bit_cyc) @(posedge pclk);
          d[i] = txd;
        end
        if (par != STSO_PAR_NONE) begin
          repeat (bit_cyc) @(posedge pclk);
          if (txd !== (par == STSO_PAR_ODD ? ~^d : ^d)) rx_err = 1'b1;
        end
        repeat (bit_cyc) @(posedge pclk);
        if (txd !== 1'b1) rx_err = 1'b1;
        rx_byte <= d;
        rx_valid <= 1'b1;
        @(posedge pclk);
        rx_valid <= 1'b0;
      end
    end
  end
endmodule : stso_rx_model

//--- dv/tb.sv
// Self-checking bench for the serial time string block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
  num_errors++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb;
  import stso_pkg::*;
  // Lowest clock the divider check accepts: 16 cycles a bit at 57600
  localparam int HZ = 921600;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic pps_pin = 1'b0;
  stso_apb_req_t req = '0;
  stso_apb_rsp_t rsp;
  stso_time_t tin;
  stso_time_t uin;
  stso_time_t b;
  stso_time_t tv[9];
  stso_time_t uv[9];
  logic [15:0] cw[9];
  string ex[8];
  int ot[8];
  int bc[4] = '{16, 48, 96, 192};
  logic txd;
  logic strobe;
  logic rx_valid;
  logic rx_err;
  logic [7:0] rx_byte;
  logic [7:0] bit_cyc = 8'd96;
  stso_par_t par = STSO_PAR_NONE;
  logic [7:0] q[$];
  logic [31:0] rd;
  logic err;
  int ot_seen;
  int num_errors;
  int comparisons;

  stso_serial_time #(.CLK_HZ(HZ)) u_dut (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .pps_pin(pps_pin), .time_in(tin),
    .utc_in(uin), .txd(txd), .ontime_strobe(strobe));
  stso_rx_model u_rx (.pclk(pclk), .txd(txd), .bit_cyc(bit_cyc), .par(par),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_err(rx_err));

  initial begin
    forever #2 pclk = ~pclk;
  end
  // Queue size at the strobe gives the on-time character's index
  always @(posedge pclk) begin
    if (rx_valid === 1'b1) q.push_back(rx_byte);
    if (strobe === 1'b1) ot_seen = q.size();
  end

  function automatic logic [15:0] cf(input int f, bd, p, ly, m);
    return {6'(m), 2'(ly), 2'(p), 2'(bd), 3'(f), 1'b1};
  endfunction : cf

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Fire the second for string i, queue settings of the next one
  task automatic run_str(input int i);
    int n;
    logic [7:0] e;
    n = 0;
    while (q.size() < ot[i] && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    repeat (100) @(posedge pclk);
    pps_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    pps_pin <= 1'b0;
    apb(1'b1, STSO_ADDR_CTRL, {16'h0, cw[i+1]});
    apb(1'b0, STSO_ADDR_CTRL, '0);
    `CHK("ctrl", {16'h0, cw[i+1]}, rd)
    tin <= tv[i+1];
    uin <= uv[i+1];
    while (q.size() < ex[i].len() && n < 80000) begin
      @(posedge pclk);
      n++;
    end
    for (int k = 0; k < ex[i].len(); k++) begin
      e = ex[i][k];
      `CHK("byte", e, q[k])
    end
    `CHK("ontime", ot[i], ot_seen)
    `CHK("frame", 1'b0, rx_err)
    bit_cyc <= 8'(bc[cw[i+1][5:4]]);
    par <= stso_par_t'(cw[i+1][7:6]);
    q.delete();
  endtask : run_str

  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    // Strings take about 88k cycles; the slow rate goes on a short one
    repeat (95000) @(posedge pclk);
    num_errors++;
    complete_run();
  end

  initial begin
    b = '{year: 14'd2024, doy: 9'd59, month: 4'd2, mday: 5'd28, wday: 3'd2,
      hour: 5'd7, minute: 6'd5, second: 6'd9, merit: 4'd5, locked: 1'b1,
      mode: STSO_MODE_UTC, default: '0};
    for (int i = 0; i < 9; i++) begin
      tv[i] = b;
      uv[i] = b;
    end
    tv[1].locked = 1'b0;
    tv[2].mode = STSO_MODE_LOCAL;
    tv[2].off_half = 5'd3;
    tv[3].locked = 1'b0;
    tv[3].off_half = 5'd3;
    tv[3].leap_cur = 8'd18;
    tv[3].leap_fut = 8'd19;
    tv[4].dst = 2'h2;
    tv[4].zone = 5'd5;
    tv[4].second = 6'd60;
    tv[5].locked = 1'b0;
    tv[5].wday = 3'd6;
    tv[5].mday = 5'd7;
    tv[5].month = 4'd12;
    tv[6].dst = 2'h3;
    tv[6].mode = STSO_MODE_LOCAL;
    tv[6].off_neg = 1'b1;
    tv[6].off_half = 5'd10;
    for (int i = 2; i < 9; i++) uv[i] = tv[i];
    uv[0].hour = 5'd13;
    cw = '{STSO_CTRL_RST, cf(1, 3, 1, 0, 32), cf(2, 0, 2, 0, 32),
      cf(3, 1, 0, 0, 32), cf(4, 0, 0, 0, 32), cf(4, 0, 0, 1, 32),
      cf(4, 0, 0, 2, 32), cf(5, 0, 0, 0, 43), cf(5, 0, 0, 0, 43)};
    ex = '{"\001059:13:05:09 \015\012", "\001059:07:05:09?\015\012",
      "5 2024 059 07:05:09 +03 L\015\012",
      "9 2024 059 07:05:09 +00 U 18 19\015\012",
      "\015\012   059 07:05:60 DTZ=05\015\012",
      "\015\012? SUN 07DEC24 07:05:09\015\012",
      "\015\012   2024 059 07:05:09 O-05\015\012",
      "$GPGGA\015\012$GPGLL\015\012$GPRMC\015\012"};
    ot = '{14, 14, 0, 0, 0, 0, 0, 0};
    tin = tv[0];
    uin = uv[0];
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    // Second edge while cluster prefix is still going out
    pps_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    pps_pin <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b0, STSO_ADDR_STAT, '0);
    `CHK("missed", 1'b1, rd[STSO_STAT_MISS_BIT])
    apb(1'b1, STSO_ADDR_STAT, 32'h1 << STSO_STAT_MISS_BIT);
    apb(1'b0, STSO_ADDR_STAT, '0);
    `CHK("cleared", 1'b0, rd[STSO_STAT_MISS_BIT])
    apb(1'b0, 32'h0000_0040, '0);
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 32'h0, rd)
    for (int i = 0; i < 8; i++) run_str(i);
    // Eight strings done; the ninth holds before its first character
    repeat (20) @(posedge pclk);
    apb(1'b0, STSO_ADDR_STAT, '0);
    `CHK("sent", 16'd8, rd[31:16])
    `CHK("holding", 1'b1, rd[1])
    complete_run();
  end
endmodule : tb

bind stso_serial_time stso_serial_time_props #(.CLK_HZ(CLK_HZ)) u_props (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .pps_pin(pps_pin), .time_in(time_in), .utc_in(utc_in), .txd(txd),
  .ontime_strobe(ontime_strobe));
